// ==== rss_sequencer.sv ====
// Reset source sequencer with AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rss_cfg.svh"

// Summary of operation
// - The latest reset cause is kept in status bits 22:20 as 1 POR, 2 pin, 3 serial line, 4 software.
// - Reset is held while the core supply is below threshold and released 500 us after it rises.
// - The external reset pin must stay low at least 2 ms before reset is entered.
// - After the pin or serial-line condition returns high, reset ends 900 us later.
// - In UART mode the receive line low for 2122 slow RC periods enters reset.
// - In SPI mode data and chip select low for 2122 slow periods with a clock over 50 Hz enters reset.
// - The serial-line detection condition follows the current communication mode.
// - Writing the 32-bit key to the write-only soft reset register resets the system.
// - A software reset ends 650 us after it is triggered.
// - On leaving reset a 1.25 ms RAM check runs and RAM opens only if it finds no error.
// - The host serial interface is idle in reset and starts as soon as reset ends.
// - A 32 kHz slow RC tick times the serial-line filter and the SPI clock window; the reset pin filter counts mclk cycles.
// - Every reset returns communication to UART mode; SPI needs a fresh host init.
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DLY_W = 20,
  parameter int POR_CYCLES = `RSS_POR_RELEASE_US * `RSS_MCLK_KHZ / 1000,
  parameter int PIN_CYCLES = `RSS_PIN_RELEASE_US * `RSS_MCLK_KHZ / 1000,
  parameter int SW_CYCLES = `RSS_SW_RELEASE_US * `RSS_MCLK_KHZ / 1000,
  parameter int RAM_CYCLES = `RSS_RAM_CHECK_US * `RSS_MCLK_KHZ / 1000,
  parameter int EXT_HOLD_CYCLES = (`RSS_EXT_HOLD_US * `RSS_MCLK_KHZ + 999) / 1000,
  parameter int LF_DIV = `RSS_MCLK_KHZ / `RSS_LFRC_KHZ,
  parameter int RX_LOW_TICKS = `RSS_RX_LOW_TICKS,
  parameter int SPI_CLK_WINDOW = `RSS_LFRC_KHZ * 1000 / `RSS_SPI_CLK_MIN_HZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset sources and pins
  input wire logic supplyAboveThreshold,
  input wire logic externalResetPinN,
  input wire logic rxPin,
  input wire logic addr1ChipSelectPin,
  input wire logic addr0SerialClockPin,
  // Serial interface and RAM check
  input wire logic spiInitDone,
  input wire logic ramCheckError,
  // Chip control
  output logic chipResetN,
  output logic serialIfEnable,
  output logic ramAccessEnable,
  output logic ramSelfCheckRun,
  output logic commModeSpi,
  output logic irq
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //----------------------------------------------------------------
  // Slow RC tick and pin conditions
  //----------------------------------------------------------------
  logic [15:0] lfCnt;
  logic [15:0] next_lfCnt;
  logic lfTick;
  logic next_lfTick;
  logic sclkQ;
  logic [15:0] sclkIdle;
  logic [15:0] next_sclkIdle;
  logic sclkActive;
  logic rxCond;
  logic extExpired;
  logic rxExpired;

  always_comb begin
    next_lfTick = (lfCnt == 16'(LF_DIV - 1));
    next_lfCnt = next_lfTick ? 16'h0000 : lfCnt + 16'h0001;
    next_sclkIdle = sclkIdle;
    if (addr0SerialClockPin != sclkQ) begin
      next_sclkIdle = 16'h0000;
    end else if (lfTick && (sclkIdle < 16'(SPI_CLK_WINDOW))) begin
      next_sclkIdle = sclkIdle + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lfCnt <= 16'h0000;
      lfTick <= 1'b0;
      sclkQ <= 1'b0;
      sclkIdle <= 16'hFFFF;
    end else begin
      lfCnt <= next_lfCnt;
      lfTick <= next_lfTick;
      sclkQ <= addr0SerialClockPin;
      sclkIdle <= next_sclkIdle;
    end
  end

  // Clock counts as toggling when an edge came within one 50 Hz period
  assign sclkActive = (sclkIdle < 16'(SPI_CLK_WINDOW));
  // Detection condition chosen by communication mode
  assign rxCond = commModeSpi ? (!rxPin && !addr1ChipSelectPin && sclkActive)
                              : !rxPin;

  rss_low_filter #(.COUNT(EXT_HOLD_CYCLES), .W(DLY_W)) u_ext_filter (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(1'b1),
    .active(!externalResetPinN),
    .expired(extExpired)
  );

  rss_low_filter #(.COUNT(RX_LOW_TICKS), .W(16)) u_rx_filter (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(lfTick),
    .active(rxCond),
    .expired(rxExpired)
  );

  //----------------------------------------------------------------
  // AXI4-Lite slave
  //----------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic next_awHeld;
  logic next_wHeld;
  logic [ADDR_W-1:0] next_awAddrQ;
  logic [31:0] next_wDataQ;
  logic [3:0] next_wStrbQ;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic doWrite;
  logic keyHit;
  logic [`RSS_IRQ_W-1:0] w1cBits;
  logic maskWrite;
  logic [`RSS_IRQ_W-1:0] irqStatus;
  logic [`RSS_IRQ_W-1:0] irqMask;
  logic [31:0] statusWord;
  rss_cause_t cause;
  logic ramOk;
  logic ramErr;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`RSS_CAUSE_MSB:`RSS_CAUSE_LSB] = cause;
    statusWord[`RSS_STS_IN_RESET] = !chipResetN;
    statusWord[`RSS_STS_RAM_OK] = ramOk;
    statusWord[`RSS_STS_RAM_ERR] = ramErr;
    statusWord[`RSS_STS_SPI_MODE] = commModeSpi;
  end

  always_comb begin
    next_awHeld = awHeld || (s_axi_awvalid && s_axi_awready);
    next_wHeld = wHeld || (s_axi_wvalid && s_axi_wready);
    next_awAddrQ = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddrQ;
    next_wDataQ = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wDataQ;
    next_wStrbQ = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrbQ;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    keyHit = 1'b0;
    w1cBits = '0;
    maskWrite = 1'b0;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (awAddrQ == ADDR_W'(`RSS_SOFT_RESET_KEY_OFFSET)) begin
        keyHit = (wDataQ == `RSS_SOFT_RESET_KEY) && (wStrbQ == 4'hF);
      end else if (awAddrQ == ADDR_W'(`RSS_IRQ_STATUS_OFFSET)) begin
        w1cBits = wStrbQ[0] ? wDataQ[`RSS_IRQ_W-1:0] : '0;
      end else if (awAddrQ == ADDR_W'(`RSS_IRQ_MASK_OFFSET)) begin
        maskWrite = wStrbQ[0];
      end else if (awAddrQ != ADDR_W'(`RSS_SYSTEM_STATUS_OFFSET)) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = !next_awHeld;
    next_wready = !next_wHeld;

    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr == ADDR_W'(`RSS_SYSTEM_STATUS_OFFSET)) begin
        next_rdata = statusWord;
      end else if (s_axi_araddr == ADDR_W'(`RSS_IRQ_STATUS_OFFSET)) begin
        next_rdata[`RSS_IRQ_W-1:0] = irqStatus;
      end else if (s_axi_araddr == ADDR_W'(`RSS_IRQ_MASK_OFFSET)) begin
        next_rdata[`RSS_IRQ_W-1:0] = irqMask;
      end else if (s_axi_araddr != ADDR_W'(`RSS_SOFT_RESET_KEY_OFFSET)) begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddrQ <= next_awAddrQ;
      wDataQ <= next_wDataQ;
      wStrbQ <= next_wStrbQ;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  //----------------------------------------------------------------
  // Reset sequence
  //----------------------------------------------------------------
  rss_state_t state;
  rss_state_t next_state;
  rss_cause_t next_cause;
  logic [DLY_W-1:0] dlyCnt;
  logic [DLY_W-1:0] next_dlyCnt;
  logic next_ramOk;
  logic next_ramErr;
  logic next_spiMode;
  rss_events_t evt;

  always_comb begin
    next_state = state;
    next_cause = cause;
    next_dlyCnt = dlyCnt;
    next_ramOk = ramOk;
    next_ramErr = ramErr;
    next_spiMode = commModeSpi;
    evt = '0;
    if (!supplyAboveThreshold) begin
      next_state = ST_HOLD;
      next_cause = CAUSE_POR;
      evt.por = !((state == ST_HOLD) && (cause == CAUSE_POR));
    end else begin
      case (state)
        ST_HOLD: begin
          if (cause == CAUSE_POR) begin
            next_state = ST_DELAY;
            next_dlyCnt = DLY_W'(POR_CYCLES);
          end else if ((cause == CAUSE_EXT) && externalResetPinN) begin
            next_state = ST_DELAY;
            next_dlyCnt = DLY_W'(PIN_CYCLES);
          end else if ((cause == CAUSE_RX) && rxPin) begin
            next_state = ST_DELAY;
            next_dlyCnt = DLY_W'(PIN_CYCLES);
          end
        end
        default: begin
          if (extExpired) begin
            next_state = ST_HOLD;
            next_cause = CAUSE_EXT;
            evt.ext = 1'b1;
          end else if (rxExpired) begin
            next_state = ST_HOLD;
            next_cause = CAUSE_RX;
            evt.rx = 1'b1;
          end else if (keyHit) begin
            next_state = ST_DELAY;
            next_cause = CAUSE_SW;
            next_dlyCnt = DLY_W'(SW_CYCLES);
            evt.sw = 1'b1;
          end else if (state == ST_DELAY) begin
            next_dlyCnt = dlyCnt - DLY_W'(1);
            if (dlyCnt <= DLY_W'(1)) begin
              next_state = ST_CHECK;
              next_dlyCnt = DLY_W'(RAM_CYCLES);
            end
          end else if (state == ST_CHECK) begin
            next_dlyCnt = dlyCnt - DLY_W'(1);
            next_ramErr = ramErr || ramCheckError;
            if (dlyCnt <= DLY_W'(1)) begin
              next_state = ST_RUN;
              next_ramOk = !next_ramErr;
              evt.ramErr = next_ramErr;
              evt.ramOk = !next_ramErr;
            end
          end else if (spiInitDone) begin
            next_spiMode = 1'b1;
          end
        end
      endcase
    end
    if (evt.por || evt.ext || evt.rx || evt.sw) begin
      next_spiMode = 1'b0;
      next_ramOk = 1'b0;
      next_ramErr = 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Interrupt status and mask
  //----------------------------------------------------------------
  logic [`RSS_IRQ_W-1:0] next_irqStatus;
  logic [`RSS_IRQ_W-1:0] next_irqMask;
  logic next_irq;

  always_comb begin
    // Set wins over a simultaneous write-one-to-clear
    next_irqStatus = (irqStatus & ~w1cBits) | evt;
    next_irqMask = maskWrite ? wDataQ[`RSS_IRQ_W-1:0] : irqMask;
    next_irq = |(next_irqStatus & next_irqMask);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_HOLD;
      cause <= CAUSE_POR;
      dlyCnt <= '0;
      ramOk <= 1'b0;
      ramErr <= 1'b0;
      commModeSpi <= 1'b0;
      chipResetN <= 1'b0;
      serialIfEnable <= 1'b0;
      ramAccessEnable <= 1'b0;
      ramSelfCheckRun <= 1'b0;
      irqStatus <= '0;
      irqMask <= `RSS_IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      cause <= next_cause;
      dlyCnt <= next_dlyCnt;
      ramOk <= next_ramOk;
      ramErr <= next_ramErr;
      commModeSpi <= next_spiMode;
      chipResetN <= (next_state == ST_CHECK) || (next_state == ST_RUN);
      serialIfEnable <= (next_state == ST_CHECK) || (next_state == ST_RUN);
      ramAccessEnable <= (next_state == ST_RUN) && next_ramOk;
      ramSelfCheckRun <= (next_state == ST_CHECK);
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      irq <= next_irq;
    end
  end

endmodule : rss_sequencer

// ==== rss_cfg.svh ====
// Offsets, field positions, reset values and timing figures of the reset sequencer
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_SOFT_RESET_KEY_OFFSET 8'h6C
`define RSS_SYSTEM_STATUS_OFFSET 8'h74
`define RSS_IRQ_STATUS_OFFSET 8'h78
`define RSS_IRQ_MASK_OFFSET 8'h7C

`define RSS_SOFT_RESET_KEY 32'h4572BEAF

`define RSS_CAUSE_MSB 22
`define RSS_CAUSE_LSB 20
`define RSS_STS_IN_RESET 0
`define RSS_STS_RAM_OK 1
`define RSS_STS_RAM_ERR 2
`define RSS_STS_SPI_MODE 3

`define RSS_IRQ_POR 0
`define RSS_IRQ_EXT 1
`define RSS_IRQ_RX 2
`define RSS_IRQ_SW 3
`define RSS_IRQ_RAM_ERR 4
`define RSS_IRQ_RAM_OK 5
`define RSS_IRQ_W 6

`define RSS_IRQ_MASK_RESET 6'h00
`define RSS_CAUSE_RESET 3'h1

`define RSS_MCLK_KHZ 25000
`define RSS_LFRC_KHZ 32
`define RSS_POR_RELEASE_US 500
`define RSS_PIN_RELEASE_US 900
`define RSS_SW_RELEASE_US 650
`define RSS_RAM_CHECK_US 1250
`define RSS_EXT_HOLD_US 2000
`define RSS_RX_LOW_TICKS 2122
`define RSS_SPI_CLK_MIN_HZ 50

`endif

// ==== rss_pkg.sv ====
// Types shared by the reset sequencer files
package rss_pkg;

  typedef enum logic [2:0] {
    CAUSE_POR = 3'h1,
    CAUSE_EXT = 3'h2,
    CAUSE_RX = 3'h3,
    CAUSE_SW = 3'h4
  } rss_cause_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_DELAY = 4'h2,
    ST_CHECK = 4'h4,
    ST_RUN = 4'h8
  } rss_state_t;

  typedef struct packed {
    logic ramOk;
    logic ramErr;
    logic sw;
    logic rx;
    logic ext;
    logic por;
  } rss_events_t;

endpackage : rss_pkg

// ==== rss_low_filter.sv ====
// Counts enabled ticks while a condition stays active and flags when the count is reached
`timescale 1ns/1ps
module rss_low_filter #(
  parameter int COUNT = 2122,
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Condition
  input wire logic tick,
  input wire logic active,
  output logic expired
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_expired;

  always_comb begin
    next_cnt = cnt;
    if (!active) begin
      next_cnt = '0;
    end else if (tick && (cnt < W'(COUNT))) begin
      next_cnt = cnt + W'(1);
    end
    next_expired = active && (next_cnt >= W'(COUNT));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end

endmodule : rss_low_filter

// ==== rss_sequencer_chk.sv ====
// Port assertions for the reset source sequencer
`timescale 1ns/1ps
module rss_sequencer_chk #(
  parameter int POR_CYCLES = 20,
  parameter int RAM_CYCLES = 40,
  parameter int EXT_HOLD_CYCLES = 30,
  parameter int LF_DIV = 4,
  parameter int RX_LOW_TICKS = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pins
  input wire logic externalResetPinN,
  input wire logic rxPin,
  // Chip control
  input wire logic chipResetN,
  input wire logic serialIfEnable,
  input wire logic ramAccessEnable,
  input wire logic ramSelfCheckRun,
  input wire logic commModeSpi,
  input wire logic irq
);
  localparam int PIN_LIM = EXT_HOLD_CYCLES + 4;
  localparam int RX_LIM = (RX_LOW_TICKS + 2) * LF_DIV + 4;
  logic [15:0] chkCnt, lowCnt, pinCnt, rxCnt;
  logic [15:0] next_chkCnt, next_lowCnt, next_pinCnt, next_rxCnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // --------------------------------
  // Cycle counters
  // --------------------------------
  always_comb begin
    next_chkCnt = ramSelfCheckRun ? chkCnt + 16'h0001 : 16'h0000;
    next_lowCnt = chipResetN ? 16'h0000 : lowCnt + 16'h0001;
    next_pinCnt = externalResetPinN ? 16'h0000 : pinCnt + 16'(pinCnt < 16'(PIN_LIM));
    next_rxCnt = (rxPin || commModeSpi) ? 16'h0000 : rxCnt + 16'(rxCnt < 16'(RX_LIM));
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chkCnt <= 16'h0000;
      lowCnt <= 16'h0000;
      pinCnt <= 16'h0000;
      rxCnt <= 16'h0000;
    end else begin
      chkCnt <= next_chkCnt;
      lowCnt <= next_lowCnt;
      pinCnt <= next_pinCnt;
      rxCnt <= next_rxCnt;
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  a_serial_idle: assert property (serialIfEnable == chipResetN)
    else $error("serial enable differs from chip run state");
  a_ram_denied: assert property (!chipResetN |-> !ramAccessEnable)
    else $error("ram open while in reset");
  a_check_closed: assert property (ramSelfCheckRun |-> !ramAccessEnable && chipResetN)
    else $error("ram open during self check");
  a_check_len: assert property ($fell(ramSelfCheckRun) && chipResetN |->
    chkCnt >= 16'(RAM_CYCLES - 1) && chkCnt <= 16'(RAM_CYCLES + 1))
    else $error("self check length wrong");
  // Power-on delay is the shortest release delay
  a_min_release: assert property ($rose(chipResetN) |-> lowCnt >= 16'(POR_CYCLES - 2))
    else $error("reset released too early");
  a_pin_enter: assert property (pinCnt == 16'(PIN_LIM) |-> !chipResetN)
    else $error("long pin low did not reset");
  a_rx_enter: assert property (rxCnt == 16'(RX_LIM) |-> !chipResetN)
    else $error("long receive low did not reset");
  a_uart_after: assert property ($fell(chipResetN) |-> ##[0:2] !commModeSpi)
    else $error("serial mode not back to uart");
  c_reset: cover property ($fell(chipResetN));
  c_ram_ok: cover property ($rose(ramAccessEnable));
  c_irq: cover property ($rose(irq));
  c_spi: cover property ($rose(commModeSpi));
endmodule : rss_sequencer_chk

bind rss_sequencer rss_sequencer_chk #(.POR_CYCLES(POR_CYCLES), .RAM_CYCLES(RAM_CYCLES),
  .EXT_HOLD_CYCLES(EXT_HOLD_CYCLES), .LF_DIV(LF_DIV), .RX_LOW_TICKS(RX_LOW_TICKS))
  i_rss_sequencer_chk (.mclk(mclk), .arst_n(arst_n), .externalResetPinN(externalResetPinN),
  .rxPin(rxPin), .chipResetN(chipResetN), .serialIfEnable(serialIfEnable),
  .ramAccessEnable(ramAccessEnable), .ramSelfCheckRun(ramSelfCheckRun),
  .commModeSpi(commModeSpi), .irq(irq));

// ==== rss_host_model.sv ====
// Host model driving the reset pin and the serial lines
`timescale 1ns/1ps
module rss_host_model (
  // Clock
  input wire logic mclk,
  // Pins
  output logic externalResetPinN,
  output logic rxPin,
  output logic addr1ChipSelectPin,
  output logic addr0SerialClockPin,
  output logic spiInitDone
);
  initial begin
    externalResetPinN = 1'b1;
    rxPin = 1'b1;
    addr1ChipSelectPin = 1'b1;
    addr0SerialClockPin = 1'b0;
    spiInitDone = 1'b0;
  end
  // Pin low for n cycles
  task automatic extLow(input int n);
    externalResetPinN <= 1'b0;
    repeat (n) @(posedge mclk);
    externalResetPinN <= 1'b1;
  endtask : extLow
  // Data low, select low if asked, clock runs only inside the frame
  task automatic rxLow(input int n, input logic csLow, input logic clk);
    rxPin <= 1'b0;
    addr1ChipSelectPin <= ~csLow;
    repeat (n) begin
      addr0SerialClockPin <= clk & ~addr0SerialClockPin;
      @(posedge mclk);
    end
    rxPin <= 1'b1;
    addr1ChipSelectPin <= 1'b1;
    addr0SerialClockPin <= 1'b0;
  endtask : rxLow
  task automatic spiInit;
    spiInitDone <= 1'b1;
    @(posedge mclk);
    spiInitDone <= 1'b0;
  endtask : spiInit
endmodule : rss_host_model

// ==== tb_rss_sequencer.sv ====
// Bench for the reset source sequencer
`timescale 1ns/1ps
`include "rss_cfg.svh"
module tb_rss_sequencer;
  localparam int POR = 20;
  localparam int PIN = 30;
  localparam int SW = 25;
  localparam int RAM = 40;
  localparam int HOLD = 30;
  localparam int RXLEN = 60;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic supply = 1'b1;
  logic ramErr = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pinN, rx, cs, sclk, spiInit;
  logic chipRstN, serEn, ramEn, ramRun, spiMode, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rnd;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  logic [33:0] rExp;
  int error_cnt = 0;
  int compares = 0;
  int dur = 0;
  int seed = 32'h5E7D91A3;
  always #20 mclk = ~mclk;
  rss_sequencer #(.POR_CYCLES(POR), .PIN_CYCLES(PIN), .SW_CYCLES(SW), .RAM_CYCLES(RAM),
    .EXT_HOLD_CYCLES(HOLD), .LF_DIV(4), .RX_LOW_TICKS(10), .SPI_CLK_WINDOW(8)) i_rss_sequencer (
    .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supplyAboveThreshold(supply), .externalResetPinN(pinN), .rxPin(rx),
    .addr1ChipSelectPin(cs), .addr0SerialClockPin(sclk), .spiInitDone(spiInit),
    .ramCheckError(ramErr), .chipResetN(chipRstN), .serialIfEnable(serEn),
    .ramAccessEnable(ramEn), .ramSelfCheckRun(ramRun), .commModeSpi(spiMode), .irq(irq));
  rss_host_model i_rss_host_model (.mclk(mclk), .externalResetPinN(pinN), .rxPin(rx),
    .addr1ChipSelectPin(cs), .addr0SerialClockPin(sclk), .spiInitDone(spiInit));
  // --------------------------------
  // Checking and closing
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("Compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic hang;
    error_cnt++;
    $display("Error %0t: wait ran out", $time);
    end_sim();
  endtask : hang
  // --------------------------------
  // Bus master
  // --------------------------------
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) hang();
    @(posedge mclk);
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) hang();
    @(posedge mclk);
  endtask : axiRd
  always @(posedge mclk) begin
    if (bvalid && bready && wq.size() > 0) check(bresp, wq.pop_front());
    if (rvalid && rready && rq.size() > 0) begin
      rExp = rq.pop_front();
      check(rdata, rExp[31:0]);
      check(rresp, rExp[33:32]);
    end
  end
  // --------------------------------
  // Reset sequence helpers
  // --------------------------------
  task automatic waitRst(input logic v);
    for (dur = 0; dur < 500 && chipRstN !== v; dur++) @(posedge mclk);
    if (dur == 500) hang();
  endtask : waitRst
  // Release delay, check window, then status word
  task automatic settle(input logic [2:0] c, input logic ok, input int e);
    waitRst(1'b0);
    waitRst(1'b1);
    check((dur >= e - 3 && dur <= e + 4) ? 32'h1 : 32'h0, 32'h1);
    check(ramRun, 1'b1);
    check(serEn, 1'b1);
    repeat (RAM + 3) @(posedge mclk);
    check(ramEn, ok);
    axiRd(8'h74, {9'h000, c, 17'h00000, ~ok, ok, 1'b0}, 2'h0);
  endtask : settle
  initial begin
    repeat (5000) @(posedge mclk);
    hang();
  end
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    settle(3'h1, 1'b1, POR);
    axiRd(8'h6C, 32'h00000000, 2'h0);
    axiRd(8'h40, 32'h00000000, 2'h2);
    axiRd(8'h7C, 32'h00000000, 2'h0);
    axiWr(8'h7C, 32'h0000003F, 2'h0);
    axiWr(8'h78, 32'h0000003F, 2'h0);
    axiWr(8'h50, 32'h00000001, 2'h2);
    axiWr(8'h74, 32'h00000000, 2'h0);
    axiRd(8'h78, 32'h00000000, 2'h0);
    wstrb <= 4'h7;
    axiWr(8'h6C, `RSS_SOFT_RESET_KEY, 2'h0);
    wstrb <= 4'hF;
    rnd = $random(seed);
    if (rnd == `RSS_SOFT_RESET_KEY) rnd = ~rnd;
    axiWr(8'h6C, rnd, 2'h0);
    repeat (5) @(posedge mclk);
    check(chipRstN, 1'b1);
    $display("Test power-on and bus done");
    axiWr(8'h6C, `RSS_SOFT_RESET_KEY, 2'h0);
    settle(3'h4, 1'b1, SW);
    axiRd(8'h78, 32'h00000028, 2'h0);
    check(irq, 1'b1);
    axiWr(8'h7C, 32'h00000000, 2'h0);
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    axiWr(8'h7C, 32'h0000003F, 2'h0);
    axiWr(8'h78, 32'h0000003F, 2'h0);
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    $display("Test software reset done");
    i_rss_host_model.extLow(HOLD - 10);
    repeat (5) @(posedge mclk);
    check(chipRstN, 1'b1);
    i_rss_host_model.extLow(HOLD + 10);
    check(chipRstN, 1'b0);
    settle(3'h2, 1'b1, PIN);
    $display("Test pin reset done");
    i_rss_host_model.rxLow(RXLEN, 1'b0, 1'b0);
    check(chipRstN, 1'b0);
    settle(3'h3, 1'b1, PIN);
    i_rss_host_model.spiInit();
    repeat (2) @(posedge mclk);
    check(spiMode, 1'b1);
    i_rss_host_model.rxLow(RXLEN, 1'b1, 1'b0);
    check(chipRstN, 1'b1);
    i_rss_host_model.rxLow(RXLEN, 1'b0, 1'b1);
    check(chipRstN, 1'b1);
    i_rss_host_model.rxLow(RXLEN, 1'b1, 1'b1);
    check(chipRstN, 1'b0);
    check(spiMode, 1'b0);
    settle(3'h3, 1'b1, PIN);
    $display("Test serial line resets done");
    ramErr <= 1'b1;
    axiWr(8'h6C, `RSS_SOFT_RESET_KEY, 2'h0);
    settle(3'h4, 1'b0, SW);
    axiRd(8'h78, 32'h0000003E, 2'h0);
    ramErr <= 1'b0;
    supply <= 1'b0;
    repeat (4) @(posedge mclk);
    check(chipRstN, 1'b0);
    supply <= 1'b1;
    settle(3'h1, 1'b1, POR);
    axiRd(8'h78, 32'h0000003F, 2'h0);
    $display("Test ram error and supply drop done");
    end_sim();
  end
endmodule : tb_rss_sequencer
